// File: inc/smem_pkg.sv
// Shared constants and types for the security module error-mode controller.
// Assumes a single 100 MHz core clock and a synchronous, active-high reset.

package smem_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_FREQ_HZ = 100_000_000;
	localparam int unsigned CLK_PER_MS = CLK_FREQ_HZ / 1000;
	// Longest allowed remaining self-test, in milliseconds
	localparam int unsigned FULL_TEST_MAX_MS = 1000;
	// Longest time rounds down to whole cycles
	localparam int unsigned FULL_TEST_MAX_CYC = FULL_TEST_MAX_MS * CLK_PER_MS;
	// Register access watchdog, cycles
	localparam int unsigned ACC_TIMEOUT_DEF = 64;
	localparam int unsigned TIMER_W = 32;

	// ---------------------------------------------------------------
	// Buffers and widths
	// ---------------------------------------------------------------
	localparam int unsigned MAX_BUF_BYTES = 3968;
	localparam int unsigned SIZE_W = 12;
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SYNC_STAGES = 2;

	// ---------------------------------------------------------------
	// Fixed answers
	// ---------------------------------------------------------------
	localparam logic [DATA_W-1:0] CRB_SHUT_STATUS = 32'h0000_0001;
	localparam logic [DATA_W-1:0] FLOAT_RDATA = 32'h0000_00FF;
	localparam logic [DATA_W-1:0] ZERO_DATA = 32'h0000_0000;

	// Response codes: values arbitrary, replace with the command set's own
	localparam logic [DATA_W-1:0] RC_FAILURE_DEF = 32'h0000_0101;
	localparam logic [DATA_W-1:0] RC_SIZE_DEF = 32'h0000_0095;
	localparam logic [DATA_W-1:0] RC_TESTING_DEF = 32'h0000_090A;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_WORK = 2'b00,
		MODE_FAIL = 2'b01,
		MODE_SHUT = 2'b10
	} smem_mode_e;

	typedef enum logic [0:0] {
		BUS_LPC = 1'b0,
		BUS_SPI = 1'b1
	} smem_bus_e;

	typedef enum logic [0:0] {
		ACC_IDLE = 1'b0,
		ACC_WAIT = 1'b1
	} smem_acc_e;

	typedef enum logic [1:0] {
		CMD_SEC_OP = 2'b00,
		CMD_DIAG = 2'b01,
		CMD_SELF_TEST = 2'b10,
		CMD_OTHER = 2'b11
	} smem_cmd_e;

endpackage

// File: rtl/smem_sync.sv
// Two-stage synchroniser with rising-edge detect on the settled output.
// Assumes the input is asynchronous to i_clk.

`timescale 1ns/1ns
`default_nettype none

module smem_sync (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_async,
	output logic o_level,
	output logic o_rise
);
	import smem_pkg::*;

	logic meta_ff;
	logic sync_ff;
	logic last_ff;

	// Stage one feeds stage two only
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			last_ff <= 1'b0;
		end else begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
			last_ff <= sync_ff;
		end
	end

	assign o_level = sync_ff;
	assign o_rise = sync_ff & ~last_ff;

endmodule

`default_nettype wire

// File: rtl/smem_error_modes.sv
// Error-mode controller of the security module: mode state, self-test
// sequencing, command gating and host register-access answers.
// Assumes a register file behind o_reg_* that acks each request, and a
// command engine that reports sizes before it executes.
//
// Overview of operation
// - Early-boot commands usable after init self-test
// - Remaining self-test ends within one second
// - Command buffer fits largest implemented command
// - Buffer size may reach 3968 bytes
// - Fail command before response buffer overflows
// - Failure mode still completes register accesses
// - Failure mode errors operations, allows diagnostics
// - Hardware attack enters shutdown until init
// - Shutdown forwards no host access to the registers
// - Shutdown: LPC ignores, SPI aborts, reads FFh
// - Shutdown buffer status reads 0001h or timeout
// - Never hang bus; complete or abort access
// - Non-attack error: error response or failure
// - Init leaves error modes unless cause persists
// - Software attacks never cause shutdown
// - Context fingerprint failure enters shutdown
// - After error, release no secrets or successes
// - Failure mode drops hash commands without stalling
// - Failure mode keeps interface registers operational
// - Init indication is reset pin rising

`timescale 1ns/1ns
`default_nettype none

module smem_error_modes #(
	parameter smem_pkg::smem_bus_e BUS_KIND = smem_pkg::BUS_LPC,
	parameter bit CRB_EN = 1'b0,
	parameter bit CRB_SHUT_DEFAULT = 1'b1,
	parameter bit ERR_TO_FAILURE = 1'b1,
	parameter bit SEPARATE_RSP_BUF = 1'b0,
	parameter int unsigned CMD_BUF_BYTES = smem_pkg::MAX_BUF_BYTES,
	parameter int unsigned RSP_BUF_BYTES = smem_pkg::MAX_BUF_BYTES,
	parameter int unsigned FULL_TEST_CYC = smem_pkg::FULL_TEST_MAX_CYC,
	parameter int unsigned ACC_TIMEOUT_CYC = smem_pkg::ACC_TIMEOUT_DEF,
	parameter logic [smem_pkg::DATA_W-1:0] RC_FAILURE = smem_pkg::RC_FAILURE_DEF,
	parameter logic [smem_pkg::DATA_W-1:0] RC_SIZE = smem_pkg::RC_SIZE_DEF,
	parameter logic [smem_pkg::DATA_W-1:0] RC_TESTING = smem_pkg::RC_TESTING_DEF
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_lpc_reset_pin_n,
	input wire logic i_hw_attack,
	input wire logic i_attack_present,
	input wire logic i_ctx_fp_fail,
	input wire logic i_sw_attack,
	input wire logic i_err_event,
	input wire logic i_err_present,
	input wire logic i_acc_req,
	input wire logic i_acc_wr,
	input wire logic [smem_pkg::ADDR_W-1:0] i_acc_addr,
	input wire logic [smem_pkg::DATA_W-1:0] i_acc_wdata,
	input wire logic i_acc_hash,
	input wire logic i_acc_crb_status,
	output logic o_acc_done,
	output logic o_acc_abort,
	output logic [smem_pkg::DATA_W-1:0] o_acc_rdata,
	output logic o_reg_req,
	output logic o_reg_wr,
	output logic [smem_pkg::ADDR_W-1:0] o_reg_addr,
	output logic [smem_pkg::DATA_W-1:0] o_reg_wdata,
	input wire logic i_reg_ack,
	input wire logic [smem_pkg::DATA_W-1:0] i_reg_rdata,
	input wire logic i_cmd_valid,
	input wire smem_pkg::smem_cmd_e i_cmd_kind,
	input wire logic i_cmd_early,
	input wire logic [smem_pkg::SIZE_W-1:0] i_cmd_bytes,
	input wire logic [smem_pkg::SIZE_W-1:0] i_rsp_bytes,
	output logic o_cmd_go,
	output logic o_cmd_err,
	output logic [smem_pkg::DATA_W-1:0] o_rsp_code,
	output logic o_early_test_start,
	input wire logic i_early_test_done,
	input wire logic i_early_test_fail,
	output logic o_full_test_start,
	input wire logic i_full_test_done,
	input wire logic i_full_test_fail,
	output logic o_early_ready,
	output logic o_full_test_done,
	output smem_pkg::smem_mode_e o_mode,
	output logic o_secret_en,
	output logic o_hw_init
);
	import smem_pkg::*;

	// ---------------------------------------------------------------
	// Init indication
	// ---------------------------------------------------------------
	logic pin_level;
	logic hw_init;

	smem_sync u_pin_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_async(i_lpc_reset_pin_n),
		.o_level(pin_level),
		.o_rise(hw_init)
	);

	// ---------------------------------------------------------------
	// Mode state
	// ---------------------------------------------------------------
	smem_mode_e mode_ff;
	smem_mode_e nxt_mode;
	logic err_seen_ff;
	logic nxt_err_seen;
	logic test_fail;
	logic to_shutdown;
	logic to_failure;
	logic soft_err;

	// Software-originated trouble is a plain error, never an attack
	assign soft_err = i_err_event | i_sw_attack;
	assign to_shutdown = i_hw_attack | i_ctx_fp_fail;
	assign to_failure = test_fail | (soft_err & ERR_TO_FAILURE);

	always_comb begin
		nxt_mode = mode_ff;
		if (hw_init) begin
			// Lingering cause, or an attack in this very cycle, wins
			if (i_attack_present | to_shutdown)
				nxt_mode = MODE_SHUT;
			else if (i_err_present)
				nxt_mode = MODE_FAIL;
			else
				nxt_mode = MODE_WORK;
		end else if (mode_ff != MODE_SHUT) begin
			if (to_shutdown)
				nxt_mode = MODE_SHUT;
			else if (to_failure)
				nxt_mode = MODE_FAIL;
		end
	end

	// Set wins over the init clear when both land together
	assign nxt_err_seen = soft_err | to_failure | to_shutdown
		| (hw_init ? (i_err_present | i_attack_present) : err_seen_ff);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			mode_ff <= MODE_WORK;
			err_seen_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			err_seen_ff <= nxt_err_seen;
		end
	end

	assign o_mode = mode_ff;
	assign o_secret_en = (mode_ff == MODE_WORK) & ~err_seen_ff;
	assign o_hw_init = hw_init;

	// ---------------------------------------------------------------
	// Self-test sequencing
	// ---------------------------------------------------------------
	logic early_ready_ff;
	logic early_run_ff;
	logic full_run_ff;
	logic full_done_ff;
	logic early_start_ff;
	logic full_start_ff;
	logic [TIMER_W-1:0] full_cnt_ff;
	logic full_start;
	logic full_timeout;

	assign full_timeout = full_run_ff
		& (full_cnt_ff >= TIMER_W'(FULL_TEST_CYC - 1));
	assign test_fail = (early_run_ff & i_early_test_fail)
		| (full_run_ff & (i_full_test_fail | full_timeout));

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			early_start_ff <= 1'b0;
			early_run_ff <= 1'b0;
			early_ready_ff <= 1'b0;
		end else begin
			early_start_ff <= hw_init;
			if (hw_init) begin
				early_run_ff <= 1'b1;
				early_ready_ff <= 1'b0;
			end else if (early_run_ff & (i_early_test_done | i_early_test_fail)) begin
				early_run_ff <= 1'b0;
				early_ready_ff <= ~i_early_test_fail;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			full_start_ff <= 1'b0;
			full_run_ff <= 1'b0;
			full_done_ff <= 1'b0;
			full_cnt_ff <= '0;
		end else begin
			full_start_ff <= full_start;
			if (hw_init) begin
				full_run_ff <= 1'b0;
				full_done_ff <= 1'b0;
				full_cnt_ff <= '0;
			end else if (full_start) begin
				full_run_ff <= 1'b1;
				full_cnt_ff <= '0;
			end else if (full_run_ff) begin
				full_cnt_ff <= full_cnt_ff + TIMER_W'(1);
				if (i_full_test_done | i_full_test_fail | full_timeout) begin
					full_run_ff <= 1'b0;
					full_done_ff <= i_full_test_done & ~i_full_test_fail & ~full_timeout;
				end
			end
		end
	end

	assign o_early_test_start = early_start_ff;
	assign o_full_test_start = full_start_ff;
	assign o_early_ready = early_ready_ff;
	assign o_full_test_done = full_done_ff;

	// ---------------------------------------------------------------
	// Command gate
	// ---------------------------------------------------------------
	logic cmd_too_big;
	logic rsp_too_big;
	logic cmd_drop;
	logic cmd_errored;
	logic cmd_untested;
	logic [DATA_W-1:0] cmd_code;
	logic cmd_go_ff;
	logic cmd_err_ff;
	logic [DATA_W-1:0] rsp_code_ff;

	assign cmd_too_big = 32'(i_cmd_bytes) > CMD_BUF_BYTES;
	// Checked up front so no partial response is ever produced
	assign rsp_too_big = SEPARATE_RSP_BUF & (32'(i_rsp_bytes) > RSP_BUF_BYTES);
	// Shutdown gives no response at all
	assign cmd_drop = mode_ff == MODE_SHUT;
	assign cmd_errored = (mode_ff == MODE_FAIL) | err_seen_ff;
	assign cmd_untested = ~early_ready_ff
		| (~full_done_ff & ~i_cmd_early & (i_cmd_kind != CMD_SELF_TEST));
	assign full_start = i_cmd_valid & ~cmd_drop & ~cmd_errored & early_ready_ff
		& (i_cmd_kind == CMD_SELF_TEST) & ~full_run_ff & ~cmd_too_big;

	always_comb begin
		cmd_code = ZERO_DATA;
		if (cmd_errored & (i_cmd_kind != CMD_DIAG))
			cmd_code = RC_FAILURE;
		else if (cmd_too_big | rsp_too_big)
			cmd_code = RC_SIZE;
		else if (cmd_untested & (i_cmd_kind != CMD_DIAG))
			cmd_code = RC_TESTING;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cmd_go_ff <= 1'b0;
			cmd_err_ff <= 1'b0;
			rsp_code_ff <= ZERO_DATA;
		end else begin
			cmd_go_ff <= i_cmd_valid & ~cmd_drop & (cmd_code == ZERO_DATA);
			cmd_err_ff <= i_cmd_valid & ~cmd_drop & (cmd_code != ZERO_DATA);
			if (i_cmd_valid & ~cmd_drop)
				rsp_code_ff <= cmd_code;
		end
	end

	assign o_cmd_go = cmd_go_ff;
	assign o_cmd_err = cmd_err_ff;
	assign o_rsp_code = rsp_code_ff;

	// ---------------------------------------------------------------
	// Host register access
	// ---------------------------------------------------------------
	smem_acc_e acc_ff;
	smem_acc_e nxt_acc;
	logic [TIMER_W-1:0] acc_cnt_ff;
	logic is_shut;
	logic shut_status;
	logic hash_drop;
	logic forward;
	logic acc_timeout;
	logic acc_done_ff;
	logic acc_abort_ff;
	logic [DATA_W-1:0] acc_rdata_ff;
	logic reg_req_ff;
	logic reg_wr_ff;
	logic [ADDR_W-1:0] reg_addr_ff;
	logic [DATA_W-1:0] reg_wdata_ff;
	logic spi_bus;

	assign spi_bus = BUS_KIND == BUS_SPI;
	assign is_shut = mode_ff == MODE_SHUT;
	assign shut_status = CRB_EN & CRB_SHUT_DEFAULT & i_acc_crb_status & ~i_acc_wr;
	// Dropped hash access, read or write: completes at once, never reaches the engine
	assign hash_drop = (mode_ff == MODE_FAIL) & i_acc_hash;
	// Failure mode forwards all but hash accesses as in working mode
	assign forward = (acc_ff == ACC_IDLE) & i_acc_req & ~is_shut & ~hash_drop;
	// Watchdog so a stuck register file cannot hang the host
	assign acc_timeout = acc_cnt_ff >= TIMER_W'(ACC_TIMEOUT_CYC - 1);

	always_comb begin
		nxt_acc = acc_ff;
		unique case (acc_ff)
			ACC_IDLE: begin
				if (forward)
					nxt_acc = ACC_WAIT;
			end
			ACC_WAIT: begin
				if (i_reg_ack | acc_timeout | is_shut)
					nxt_acc = ACC_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			acc_ff <= ACC_IDLE;
			acc_cnt_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
			acc_cnt_ff <= (acc_ff == ACC_WAIT) ? acc_cnt_ff + TIMER_W'(1) : '0;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			reg_req_ff <= 1'b0;
			reg_wr_ff <= 1'b0;
			reg_addr_ff <= '0;
			reg_wdata_ff <= ZERO_DATA;
		end else begin
			reg_req_ff <= forward;
			if (forward) begin
				reg_wr_ff <= i_acc_wr;
				reg_addr_ff <= i_acc_addr;
				reg_wdata_ff <= i_acc_wdata;
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			acc_done_ff <= 1'b0;
			acc_abort_ff <= 1'b0;
			acc_rdata_ff <= ZERO_DATA;
		end else begin
			acc_done_ff <= 1'b0;
			acc_abort_ff <= 1'b0;
			if ((acc_ff == ACC_IDLE) & i_acc_req) begin
				if (is_shut & shut_status) begin
					acc_done_ff <= 1'b1;
					acc_rdata_ff <= CRB_SHUT_STATUS;
				end else if (is_shut) begin
					// LPC stays silent; the host sees a floating bus
					acc_abort_ff <= spi_bus;
					acc_rdata_ff <= FLOAT_RDATA;
				end else if (hash_drop) begin
					acc_done_ff <= 1'b1;
					acc_rdata_ff <= ZERO_DATA;
				end
			end else if (acc_ff == ACC_WAIT) begin
				if (is_shut) begin
					acc_abort_ff <= spi_bus;
					acc_rdata_ff <= FLOAT_RDATA;
				end else if (i_reg_ack) begin
					acc_done_ff <= 1'b1;
					acc_rdata_ff <= i_reg_wr_rdata(reg_wr_ff, i_reg_rdata);
				end else if (acc_timeout) begin
					acc_abort_ff <= 1'b1;
					acc_rdata_ff <= FLOAT_RDATA;
				end
			end
		end
	end

	// Writes return zero so stale read data never leaks
	function automatic logic [DATA_W-1:0] i_reg_wr_rdata(
		input logic wr,
		input logic [DATA_W-1:0] rd
	);
		return wr ? ZERO_DATA : rd;
	endfunction

	assign o_acc_done = acc_done_ff;
	assign o_acc_abort = acc_abort_ff;
	assign o_acc_rdata = acc_rdata_ff;
	assign o_reg_req = reg_req_ff;
	assign o_reg_wr = reg_wr_ff;
	assign o_reg_addr = reg_addr_ff;
	assign o_reg_wdata = reg_wdata_ff;

	// Pin level kept for visibility of a held reset; no logic needs it
	logic unused_pin;
	assign unused_pin = pin_level;

endmodule

`default_nettype wire

// File: dv/smem_error_modes_asserts.sv
// Port checks of the error-mode controller, bound into every instance.
// Assumes the LPC flavour, where a shut-down device answers nothing.
`timescale 1ns/1ns
`default_nettype none
module smem_error_modes_asserts (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_hw_attack,
	input wire logic i_attack_present,
	input wire logic i_ctx_fp_fail,
	input wire logic i_err_present,
	input wire logic i_cmd_valid,
	input wire smem_pkg::smem_cmd_e i_cmd_kind,
	input wire logic o_acc_done,
	input wire logic o_acc_abort,
	input wire logic o_reg_req,
	input wire logic o_cmd_go,
	input wire logic o_cmd_err,
	input wire logic [smem_pkg::DATA_W-1:0] o_rsp_code,
	input wire smem_pkg::smem_mode_e o_mode,
	input wire logic o_secret_en,
	input wire logic o_hw_init
);
	import smem_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// No init or attack competing in this cycle
	wire logic calm;
	assign calm = !o_hw_init && !i_hw_attack && !i_ctx_fp_fail;
	a_attack_shut: assert property (i_hw_attack |=> o_mode == MODE_SHUT)
		else $error("attack did not shut down");
	a_shut_held: assert property (o_mode == MODE_SHUT && !o_hw_init |=> o_mode == MODE_SHUT)
		else $error("shutdown left without init");
	a_fp_shut: assert property (i_ctx_fp_fail |=> o_mode == MODE_SHUT)
		else $error("fingerprint fail did not shut down");
	a_init_clears: assert property (o_hw_init && !i_attack_present && !i_err_present
		&& !i_hw_attack && !i_ctx_fp_fail |=> o_mode == MODE_WORK) else $error("init kept mode");
	a_secret_gate: assert property (o_mode != MODE_WORK |-> !o_secret_en)
		else $error("secrets enabled in error mode");
	a_fail_refuses: assert property (o_mode == MODE_FAIL && i_cmd_valid && i_cmd_kind != CMD_DIAG
		&& calm |=> o_cmd_err && !o_cmd_go && o_rsp_code == RC_FAILURE_DEF)
		else $error("failure mode let an operation through");
	a_shut_silent: assert property (o_mode == MODE_SHUT && i_cmd_valid && calm
		|=> !o_cmd_go && !o_cmd_err) else $error("shutdown answered a command");
	a_no_hang: assert property (o_reg_req |-> ##[1:80] (o_acc_done || o_acc_abort
		|| o_mode == MODE_SHUT)) else $error("forwarded access hung");
endmodule
bind smem_error_modes smem_error_modes_asserts u_chk (.i_clk(i_clk), .i_rst(i_rst),
	.i_hw_attack(i_hw_attack), .i_attack_present(i_attack_present),
	.i_ctx_fp_fail(i_ctx_fp_fail), .i_err_present(i_err_present), .i_cmd_valid(i_cmd_valid),
	.i_cmd_kind(i_cmd_kind), .o_acc_done(o_acc_done), .o_acc_abort(o_acc_abort),
	.o_reg_req(o_reg_req), .o_cmd_go(o_cmd_go), .o_cmd_err(o_cmd_err),
	.o_rsp_code(o_rsp_code), .o_mode(o_mode), .o_secret_en(o_secret_en), .o_hw_init(o_hw_init));
`default_nettype wire

// File: dv/smem_regfile_model.sv
// Register file behind forwarded host accesses.
// Answers after i_lat idle cycles; 4'hF never answers, to force a timeout.
`timescale 1ns/1ns
`default_nettype none
module smem_regfile_model (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_wr,
	input wire logic [15:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_lat,
	output logic o_ack,
	output logic [31:0] o_rdata
);
	logic [31:0] mem [16];
	logic [31:0] wd_ff;
	logic [3:0] cnt_ff, ad_ff;
	logic busy_ff, wr_ff;
	always_ff @(posedge i_clk) begin
		o_ack <= 1'b0;
		// Data toggles outside the answer so stale values never look valid
		o_rdata <= ~o_rdata;
		if (i_rst) begin
			busy_ff <= 1'b0;
			o_rdata <= 32'h0000_0000;
		end else if (i_req) begin
			busy_ff <= 1'b1;
			cnt_ff <= i_lat;
			ad_ff <= i_addr[3:0];
			wr_ff <= i_wr;
			wd_ff <= i_wdata;
		end else if (busy_ff && cnt_ff != 4'h0 && i_lat != 4'hF) begin
			cnt_ff <= cnt_ff - 4'h1;
		end else if (busy_ff && i_lat != 4'hF) begin
			busy_ff <= 1'b0;
			o_ack <= 1'b1;
			o_rdata <= wr_ff ? 32'h0000_0000 : mem[ad_ff];
			if (wr_ff) mem[ad_ff] <= wd_ff;
		end
	end
endmodule
`default_nettype wire

// File: dv/smem_error_modes_test.sv
// Bench for the error-mode controller: boot, self-test, accesses, modes.
// Assumes the register file model on the forwarded access port.
`timescale 1ns/1ns
`default_nettype none
module smem_error_modes_test;
	import smem_pkg::*;
	logic i_clk, i_rst, pin_n, hw_att, att_pres, fp_fail, sw_att, err_ev, err_pres;
	logic acc_req, acc_wr, acc_hash, acc_crb, acc_done, acc_abort, reg_req, reg_wr, reg_ack;
	logic cmd_valid, cmd_early, cmd_go, cmd_err, e_start, e_done, f_start, f_done, fst;
	logic early_ready, full_done, secret_en, e_fail, f_fail, ef_sel, hw_init;
	logic [ADDR_W-1:0] acc_addr, reg_addr;
	logic [DATA_W-1:0] acc_wdata, acc_rdata, reg_wdata, reg_rdata, rsp_code;
	logic [SIZE_W-1:0] cmd_bytes;
	logic [3:0] lat;
	smem_cmd_e cmd_kind;
	smem_mode_e mode;
	int errors = 0;
	int n_checks = 0;
	int nreg = 0;
	int ninit = 0;
	logic [3:0] lat_tab [2] = '{4'h0, 4'h3};
	smem_error_modes #(.CRB_EN(1'b1), .CMD_BUF_BYTES(64), .FULL_TEST_CYC(200),
		.ACC_TIMEOUT_CYC(8)) DUT (
		.i_clk(i_clk), .i_rst(i_rst), .i_lpc_reset_pin_n(pin_n), .i_hw_attack(hw_att),
		.i_attack_present(att_pres), .i_ctx_fp_fail(fp_fail), .i_sw_attack(sw_att),
		.i_err_event(err_ev), .i_err_present(err_pres), .i_acc_req(acc_req), .i_acc_wr(acc_wr),
		.i_acc_addr(acc_addr), .i_acc_wdata(acc_wdata), .i_acc_hash(acc_hash),
		.i_acc_crb_status(acc_crb), .o_acc_done(acc_done), .o_acc_abort(acc_abort),
		.o_acc_rdata(acc_rdata), .o_reg_req(reg_req), .o_reg_wr(reg_wr), .o_reg_addr(reg_addr),
		.o_reg_wdata(reg_wdata), .i_reg_ack(reg_ack), .i_reg_rdata(reg_rdata),
		.i_cmd_valid(cmd_valid), .i_cmd_kind(cmd_kind), .i_cmd_early(cmd_early),
		.i_cmd_bytes(cmd_bytes), .i_rsp_bytes(12'h000), .o_cmd_go(cmd_go), .o_cmd_err(cmd_err),
		.o_rsp_code(rsp_code), .o_early_test_start(e_start), .i_early_test_done(e_done),
		.i_early_test_fail(e_fail), .o_full_test_start(f_start), .i_full_test_done(f_done),
		.i_full_test_fail(f_fail), .o_early_ready(early_ready), .o_full_test_done(full_done),
		.o_mode(mode), .o_secret_en(secret_en), .o_hw_init(hw_init));
	smem_regfile_model PM (.i_clk(i_clk), .i_rst(i_rst), .i_req(reg_req), .i_wr(reg_wr),
		.i_addr(reg_addr), .i_wdata(reg_wdata), .i_lat(lat), .o_ack(reg_ack),
		.o_rdata(reg_rdata));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Early test engine answers at once; ef_sel makes it fail
	always @(negedge i_clk) {e_done, e_fail} <= {e_start & ~ef_sel, e_start & ef_sel};
	always @(posedge i_clk) if (reg_req === 1'b1) nreg <= nreg + 1;
	always @(posedge i_clk) if (hw_init === 1'b1) ninit <= ninit + 1;
	// ---
	// Shared tasks
	// ---
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string m);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
		end
	endtask
	task automatic chk_mode(input smem_mode_e exp);
		n_checks++;
		if (mode !== exp) begin
			errors++;
			$display("unexpected at %0t: mode %b want %b", $time, mode, exp);
		end
	endtask
	task automatic nc(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
		input logic h, input logic c, output logic [1:0] res);
		@(negedge i_clk);
		{acc_req, acc_wr, acc_addr, acc_wdata, acc_hash, acc_crb} = {1'b1, w, a, d, h, c};
		@(negedge i_clk);
		acc_req = 1'b0;
		res = 2'b00;
		for (int i = 0; i < 20 && res == 2'b00; i++) begin
			if (acc_done === 1'b1) res = 2'b01;
			else if (acc_abort === 1'b1) res = 2'b10;
			else @(negedge i_clk);
		end
	endtask
	task automatic cmd(input smem_cmd_e k, input logic e, input logic [11:0] b,
		output logic [1:0] ge);
		@(negedge i_clk);
		{cmd_valid, cmd_early, cmd_bytes} = {1'b1, e, b};
		cmd_kind = k;
		@(negedge i_clk);
		cmd_valid = 1'b0;
		ge = {cmd_go, cmd_err};
		fst = f_start;
	endtask
	task automatic init(input logic ap, input logic ep);
		{att_pres, err_pres, pin_n} = {ap, ep, 1'b0};
		nc(3);
		pin_n = 1'b1;
		nc(12);
		{att_pres, err_pres} = 2'b00;
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// ---
	// Scenarios
	// ---
	task automatic t_boot_self;
		logic [1:0] ge;
		cmd(CMD_OTHER, 1'b1, 12'h010, ge);
		chk(rsp_code, RC_TESTING_DEF, "code before init");
		init(1'b0, 1'b0);
		chk({ninit, early_ready, secret_en}, {32'd1, 2'b11}, "init seen once");
		cmd(CMD_OTHER, 1'b1, 12'h010, ge);
		chk(ge, 2'b10, "early cmd");
		cmd(CMD_OTHER, 1'b0, 12'h010, ge);
		chk(ge, 2'b01, "late cmd before test");
		cmd(CMD_SELF_TEST, 1'b1, 12'h010, ge);
		chk({ge, fst}, 3'b101, "self test go");
		f_done = 1'b1;
		nc(1);
		f_done = 1'b0;
		nc(1);
		chk(full_done, 1'b1, "full test done");
		cmd(CMD_OTHER, 1'b0, 12'h041, ge);
		chk(rsp_code, RC_SIZE_DEF, "oversize");
		cmd(CMD_OTHER, 1'b0, 12'h040, ge);
		chk(ge, 2'b10, "largest fits");
		$display("boot and self test finished");
	endtask
	task automatic t_regs_fail;
		logic [1:0] r;
		int n0;
		foreach (lat_tab[i]) begin
			lat = lat_tab[i];
			acc(1'b1, 16'h0003, 32'h1234_5678 + i, 1'b0, 1'b0, r);
			acc(1'b0, 16'h0003, 32'h0000_0000, 1'b0, 1'b0, r);
			chk(acc_rdata, 32'h1234_5678 + i, "read back");
		end
		lat = 4'hF;
		acc(1'b0, 16'h0003, 32'h0000_0000, 1'b0, 1'b0, r);
		chk(r, 2'b10, "timeout abort");
		lat = 4'h1;
		acc(1'b0, 16'h0003, 32'h0000_0000, 1'b0, 1'b0, r);
		chk({r, acc_rdata}, {2'b01, 32'h1234_5679}, "retry after abort");
		err_ev = 1'b1;
		nc(1);
		err_ev = 1'b0;
		nc(2);
		chk_mode(MODE_FAIL);
		chk(secret_en, 1'b0, "secrets off");
		cmd(CMD_DIAG, 1'b1, 12'h010, r);
		chk(r, 2'b10, "diagnostic allowed");
		cmd(CMD_SEC_OP, 1'b1, 12'h010, r);
		chk({r, rsp_code}, {2'b01, RC_FAILURE_DEF}, "operation refused");
		acc(1'b1, 16'h0005, 32'hA5A5_0F0F, 1'b0, 1'b0, r);
		acc(1'b0, 16'h0005, 32'h0000_0000, 1'b0, 1'b0, r);
		chk(acc_rdata, 32'hA5A5_0F0F, "fail mode access");
		n0 = nreg;
		acc(1'b1, 16'h0006, 32'h0000_0000, 1'b1, 1'b0, r);
		chk({r, nreg == n0}, 3'b011, "hash dropped");
		init(1'b0, 1'b1);
		chk_mode(MODE_FAIL);
		init(1'b0, 1'b0);
		chk_mode(MODE_WORK);
		$display("registers and failure mode finished");
	endtask
	task automatic t_shut;
		logic [1:0] r;
		sw_att = 1'b1;
		nc(1);
		sw_att = 1'b0;
		nc(2);
		chk_mode(MODE_FAIL);
		init(1'b0, 1'b0);
		hw_att = 1'b1;
		nc(1);
		hw_att = 1'b0;
		nc(2);
		chk_mode(MODE_SHUT);
		acc(1'b0, 16'h0000, 32'h0000_0000, 1'b0, 1'b0, r);
		chk({r, acc_rdata}, {2'b00, FLOAT_RDATA}, "ignored access");
		acc(1'b0, 16'h0040, 32'h0000_0000, 1'b0, 1'b1, r);
		chk({r, acc_rdata}, {2'b01, CRB_SHUT_STATUS}, "status read");
		cmd(CMD_OTHER, 1'b1, 12'h010, r);
		chk(r, 2'b00, "shutdown silent");
		init(1'b1, 1'b0);
		chk_mode(MODE_SHUT);
		init(1'b0, 1'b0);
		chk_mode(MODE_WORK);
		fp_fail = 1'b1;
		nc(1);
		fp_fail = 1'b0;
		nc(2);
		chk_mode(MODE_SHUT);
		init(1'b0, 1'b0);
		cmd(CMD_SELF_TEST, 1'b1, 12'h010, r);
		f_fail = 1'b1;
		nc(1);
		f_fail = 1'b0;
		nc(2);
		chk_mode(MODE_FAIL);
		ef_sel = 1'b1;
		init(1'b0, 1'b0);
		chk({early_ready, mode}, {1'b0, MODE_FAIL}, "early test fail");
		ef_sel = 1'b0;
		init(1'b0, 1'b0);
		cmd(CMD_SELF_TEST, 1'b1, 12'h010, r);
		nc(199);
		chk_mode(MODE_WORK);
		nc(1);
		chk_mode(MODE_FAIL);
		$display("shutdown and test limit finished");
	endtask
	initial begin
		{pin_n, hw_att, att_pres, fp_fail, sw_att, err_ev, err_pres, f_done} = 8'h00;
		{acc_req, acc_wr, acc_hash, acc_crb, cmd_valid, cmd_early} = 6'h00;
		{acc_addr, acc_wdata, cmd_bytes, lat, ef_sel, f_fail} = '0;
		cmd_kind = CMD_OTHER;
		i_rst = 1'b1;
		nc(3);
		i_rst = 1'b0;
		t_boot_self;
		t_regs_fail;
		t_shut;
		conclude;
	end
	initial begin
		#200_000;
		errors++;
		conclude;
	end
endmodule
`default_nettype wire
